/* core/qsp_array.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module qsp_array
(
    qsp_mem_if.mem port // array access
);
    import qsp_pkg::*;

    localparam int DEPTH = 1 << `QSP_MEM_AW;

    // the four internal arrays are the two low address bits' worth of depth
    logic [`QSP_NBYTES-1:0][`QSP_BYTE_W-1:0] mem_r [DEPTH];
    qsp_word_t rdata_r;

    always_ff @(posedge port.clk)
    begin
        if (port.we)
        begin
            for (int i = 0; i < `QSP_NBYTES; i++)
            begin
                if (port.wbe[i])
                begin
                    mem_r[port.waddr][i] <= port.wdata[i*`QSP_BYTE_W +: `QSP_BYTE_W];
                end
            end
        end
        if (port.re)
        begin
            rdata_r <= mem_r[port.raddr];
        end
    end

    assign port.rdata = rdata_r;

endmodule : qsp_array

`default_nettype wire

/* core/qsp_consts.svh */
`ifndef QSP_CONSTS_SVH
`define QSP_CONSTS_SVH
// Behaviour
// - write data sampled on rising edges of both input clocks during writes.
// - write select low at positive clock edge starts a write.
// - write select high deselects the write port; write data ignored.
// - byte selects low choose written bytes; unselected bytes keep old contents.
// - each byte select sampled with its data; lane n covers bits 9n+8 to 9n.
// - byte select high discards its nine-bit byte.
// - one address bus shared by read and write, sampled at positive edge.
// - four arrays; 18 address inputs reach the wide array.
// - address ignored for a port whose select is high.
// - read data driven on rising edges of both input clocks.
// - read select low at positive clock edge starts a read.
// - on deselect, pending read completes, then outputs float after next edge.
// - every read returns a burst of four transfers.
// - valid flag high while data valid, aligned with echo clocks.
// - accesses start only at positive clock rising edge.
// - negative clock edge captures inputs and drives output data.
// - free-running echo clocks follow the positive input clock; here they stop, echo low, while the link is in reset.
`define QSP_DW 36
`define QSP_BYTE_W 9
`define QSP_NBYTES 4
`define QSP_AW 18
`define QSP_BEATS 4
`define QSP_BEAT_W 2
`define QSP_MEM_AW 20
`define QSP_ARRAYS 4
`define QSP_LAST_BEAT 2'h3
`define QSP_BANKS 2
`endif

/* core/qsp_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface qsp_mem_if
(
    input wire logic clk
);
    import qsp_pkg::*;

    logic we;
    qsp_maddr_t waddr;
    qsp_word_t wdata;
    qsp_mask_t wbe;
    logic re;
    qsp_maddr_t raddr;
    qsp_word_t rdata;

    modport ctrl (input clk, output we, waddr, wdata, wbe, re, raddr, input rdata);
    modport mem (input clk, input we, waddr, wdata, wbe, re, raddr, output rdata);

endinterface : qsp_mem_if

`default_nettype wire

/* core/qsp_pkg.sv */
`default_nettype none
`include "qsp_consts.svh"

package qsp_pkg;

    typedef logic [`QSP_DW-1:0] qsp_word_t;
    typedef logic [`QSP_NBYTES-1:0] qsp_mask_t;
    typedef logic [`QSP_AW-1:0] qsp_addr_t;
    typedef logic [`QSP_MEM_AW-1:0] qsp_maddr_t;
    typedef logic [`QSP_BEAT_W-1:0] qsp_beat_t;
    typedef logic [`QSP_BEATS-1:0][`QSP_DW-1:0] qsp_burst_t;
    typedef logic [`QSP_BEATS-1:0][`QSP_NBYTES-1:0] qsp_bmask_t;

    typedef enum logic [1:0] {
        QSP_RD_IDLE = 2'h0,
        QSP_RD_ISSUE = 2'h1,
        QSP_RD_DRAIN = 2'h3,
        QSP_RD_DONE = 2'h2
    } qsp_rd_st_t;

    // system clock side: array engines
    typedef struct packed {
        logic [1:0] wr_sync;
        logic wr_seen;
        logic [1:0] rd_sync;
        logic rd_seen;
        logic wr_run;
        qsp_beat_t wbeat;
        qsp_addr_t w_addr;
        qsp_burst_t w_d;
        qsp_bmask_t w_m;
        logic we;
        qsp_maddr_t waddr;
        qsp_word_t wdata;
        qsp_mask_t wbe;
        qsp_rd_st_t rd_st;
        qsp_beat_t rbeat;
        qsp_addr_t r_addr;
        logic r_par;
        logic re;
        qsp_maddr_t raddr;
        logic rv;
        qsp_beat_t rvb;
        logic [`QSP_BANKS-1:0][`QSP_BEATS-1:0][`QSP_DW-1:0] bank;
        logic done_tog;
    } qsp_sys_t;

    // positive link clock side
    typedef struct packed {
        logic tp;
        logic rd_blocked;
        logic rd_tog;
        qsp_addr_t rd_addr;
        logic [1:0] done_sync;
        logic done_seen;
        logic rd_par;
        logic out_half;
        qsp_word_t q_pos;
        qsp_word_t neg_word;
        qsp_word_t ob2;
        qsp_word_t ob3;
        logic vld_pos;
        logic wr_act;
        logic wr_fin;
        qsp_addr_t st_addr;
        logic [2:0][`QSP_DW-1:0] st_d;
        logic [2:0][`QSP_NBYTES-1:0] st_m;
        logic wr_tog;
        qsp_addr_t h_addr;
        qsp_burst_t h_d;
        qsp_bmask_t h_m;
    } qsp_link_t;

    // negative link clock side
    typedef struct packed {
        logic tn;
        qsp_word_t q_neg;
        logic vld_neg;
        qsp_word_t d_cap;
        qsp_mask_t m_cap;
    } qsp_neg_t;

endpackage : qsp_pkg

`default_nettype wire

/* core/qsp_sram_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module qsp_sram_port
(
    input wire logic clk_i, // system clock for the array
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic k_clk_i, // positive input clock
    input wire logic k_n_clk_i, // negative input clock
    input wire logic read_port_select_n_i, // read select, active low
    input wire logic write_port_select_n_i, // write select, active low
    input wire qsp_pkg::qsp_mask_t byte_write_select_n_i, // byte selects, active low
    input wire qsp_pkg::qsp_addr_t addr_i, // shared burst address
    input wire qsp_pkg::qsp_word_t data_i, // write data
    output logic [`QSP_DW-1:0] q_o, // read data
    output logic q_oe_o, // read data drive enable
    output logic output_valid_flag_o, // read data valid
    output logic echo_timing_out_o, // echo clock
    output logic echo_timing_out_n_o // inverted echo clock
);
    import qsp_pkg::*;

    qsp_sys_t sys_r;
    qsp_sys_t sys_nxt;
    qsp_link_t lnk_r;
    qsp_link_t lnk_nxt;
    qsp_neg_t neg_r;
    qsp_neg_t neg_nxt;
    logic k_rst_meta_r;
    logic k_rst_n_r;
    logic phase;

    qsp_mem_if mem_if (.clk(clk_i));

    qsp_array u_array
    (
        .port(mem_if.mem)
    );

    assign mem_if.we = sys_r.we;
    assign mem_if.waddr = sys_r.waddr;
    assign mem_if.wdata = sys_r.wdata;
    assign mem_if.wbe = sys_r.wbe;
    assign mem_if.re = sys_r.re;
    assign mem_if.raddr = sys_r.raddr;

    // reset level carried into the link domain
    always_ff @(posedge k_clk_i)
    begin
        k_rst_meta_r <= rst_n_i;
        k_rst_n_r <= k_rst_meta_r;
    end

    // array engines on the system clock; bursts arrive by toggle handshake,
    // and the held words stay put for a full burst period, so one copy is safe
    always_comb
    begin
        sys_nxt = sys_r;
        sys_nxt.wr_sync = {sys_r.wr_sync[0], lnk_r.wr_tog};
        sys_nxt.rd_sync = {sys_r.rd_sync[0], lnk_r.rd_tog};
        sys_nxt.we = 1'b0;
        sys_nxt.re = 1'b0;
        sys_nxt.rv = sys_r.re;
        sys_nxt.rvb = sys_r.raddr[`QSP_BEAT_W-1:0];

        if (sys_r.wr_run)
        begin
            sys_nxt.we = 1'b1;
            sys_nxt.waddr = {sys_r.w_addr, sys_r.wbeat};
            sys_nxt.wdata = sys_r.w_d[sys_r.wbeat];
            sys_nxt.wbe = ~sys_r.w_m[sys_r.wbeat];
            sys_nxt.wbeat = sys_r.wbeat + 2'h1;
            if (sys_r.wbeat == `QSP_LAST_BEAT)
            begin
                sys_nxt.wr_run = 1'b0;
            end
        end
        else if (sys_r.wr_sync[1] != sys_r.wr_seen)
        begin
            sys_nxt.wr_seen = sys_r.wr_sync[1];
            sys_nxt.w_addr = lnk_r.h_addr;
            sys_nxt.w_d = lnk_r.h_d;
            sys_nxt.w_m = lnk_r.h_m;
            sys_nxt.wbeat = 2'h0;
            sys_nxt.wr_run = 1'b1;
        end

        if (sys_r.rv)
        begin
            sys_nxt.bank[sys_r.r_par][sys_r.rvb] = mem_if.rdata;
        end

        case (sys_r.rd_st)
            QSP_RD_IDLE:
            begin
                if (sys_r.rd_sync[1] != sys_r.rd_seen)
                begin
                    sys_nxt.rd_seen = sys_r.rd_sync[1];
                    sys_nxt.r_addr = lnk_r.rd_addr;
                    sys_nxt.rbeat = 2'h0;
                    sys_nxt.rd_st = QSP_RD_ISSUE;
                end
            end
            QSP_RD_ISSUE:
            begin
                sys_nxt.re = 1'b1;
                sys_nxt.raddr = {sys_r.r_addr, sys_r.rbeat};
                sys_nxt.rbeat = sys_r.rbeat + 2'h1;
                if (sys_r.rbeat == `QSP_LAST_BEAT)
                begin
                    sys_nxt.rd_st = QSP_RD_DRAIN;
                end
            end
            QSP_RD_DRAIN:
            begin
                if (sys_r.rv && sys_r.rvb == `QSP_LAST_BEAT)
                begin
                    sys_nxt.rd_st = QSP_RD_DONE;
                end
            end
            QSP_RD_DONE:
            begin
                // the bank is complete before the toggle moves
                sys_nxt.done_tog = ~sys_r.done_tog;
                sys_nxt.r_par = ~sys_r.r_par;
                sys_nxt.rd_st = QSP_RD_IDLE;
            end
            default:
            begin
                sys_nxt.rd_st = QSP_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sys_r <= '0;
        end
        else
        begin
            sys_r <= sys_nxt;
        end
    end

    // positive-edge link logic: accesses start here only
    always_comb
    begin
        logic rd_go;
        logic wr_go;
        logic done_ev;
        rd_go = 1'b0;
        wr_go = 1'b0;
        done_ev = 1'b0;
        lnk_nxt = lnk_r;
        lnk_nxt.tp = ~lnk_r.tp;
        lnk_nxt.done_sync = {lnk_r.done_sync[0], sys_r.done_tog};

        // a read on the edge right after an accepted one would overlap bursts
        rd_go = !read_port_select_n_i && !lnk_r.rd_blocked;
        lnk_nxt.rd_blocked = rd_go;
        if (rd_go)
        begin
            lnk_nxt.rd_addr = addr_i;
            lnk_nxt.rd_tog = ~lnk_r.rd_tog;
        end

        // held burst is copied out before the staging words are reused
        lnk_nxt.wr_fin = lnk_r.wr_act;
        if (lnk_r.wr_fin)
        begin
            lnk_nxt.h_addr = lnk_r.st_addr;
            lnk_nxt.h_d = {neg_r.d_cap, lnk_r.st_d[2], lnk_r.st_d[1], lnk_r.st_d[0]};
            lnk_nxt.h_m = {neg_r.m_cap, lnk_r.st_m[2], lnk_r.st_m[1], lnk_r.st_m[0]};
            lnk_nxt.wr_tog = ~lnk_r.wr_tog;
        end

        wr_go = !write_port_select_n_i && !lnk_r.wr_act;
        lnk_nxt.wr_act = wr_go;
        if (wr_go)
        begin
            lnk_nxt.st_addr = addr_i;
            lnk_nxt.st_d[0] = data_i;
            lnk_nxt.st_m[0] = byte_write_select_n_i;
        end
        if (lnk_r.wr_act)
        begin
            lnk_nxt.st_d[1] = neg_r.d_cap;
            lnk_nxt.st_m[1] = neg_r.m_cap;
            lnk_nxt.st_d[2] = data_i;
            lnk_nxt.st_m[2] = byte_write_select_n_i;
        end
        // with the write port deselected and no burst collecting, nothing above
        // moves, so the data bus is simply not looked at

        // a finished read burst waits while the second half is still going out
        done_ev = (lnk_r.done_sync[1] != lnk_r.done_seen) && !lnk_r.out_half;
        if (done_ev)
        begin
            lnk_nxt.done_seen = lnk_r.done_sync[1];
            lnk_nxt.q_pos = sys_r.bank[lnk_r.rd_par][0];
            lnk_nxt.neg_word = sys_r.bank[lnk_r.rd_par][1];
            lnk_nxt.ob2 = sys_r.bank[lnk_r.rd_par][2];
            lnk_nxt.ob3 = sys_r.bank[lnk_r.rd_par][3];
            lnk_nxt.rd_par = ~lnk_r.rd_par;
            lnk_nxt.out_half = 1'b1;
            lnk_nxt.vld_pos = 1'b1;
        end
        else if (lnk_r.out_half)
        begin
            lnk_nxt.q_pos = lnk_r.ob2;
            lnk_nxt.neg_word = lnk_r.ob3;
            lnk_nxt.out_half = 1'b0;
            lnk_nxt.vld_pos = 1'b1;
        end
        else
        begin
            lnk_nxt.vld_pos = 1'b0;
        end
    end

    always_ff @(posedge k_clk_i)
    begin
        if (!k_rst_n_r)
        begin
            lnk_r <= '0;
        end
        else
        begin
            lnk_r <= lnk_nxt;
        end
    end

    // negative-edge link logic: second and fourth beats both ways
    always_comb
    begin
        neg_nxt = neg_r;
        neg_nxt.tn = lnk_r.tp;
        neg_nxt.q_neg = lnk_r.neg_word;
        neg_nxt.vld_neg = lnk_r.vld_pos;
        // captured every edge; only used while a write burst is collecting
        neg_nxt.d_cap = data_i;
        neg_nxt.m_cap = byte_write_select_n_i;
    end

    always_ff @(posedge k_n_clk_i)
    begin
        if (!k_rst_n_r)
        begin
            neg_r <= '0;
        end
        else
        begin
            neg_r <= neg_nxt;
        end
    end

    // double-rate output stage: high after a positive edge, low after a
    // negative one; the select is itself the echo clock, so data, valid and
    // echo change together
    assign phase = lnk_r.tp ^ neg_r.tn;
    assign echo_timing_out_o = phase;
    assign echo_timing_out_n_o = ~phase;
    assign q_o = phase ? lnk_r.q_pos : neg_r.q_neg;
    assign output_valid_flag_o = phase ? lnk_r.vld_pos : neg_r.vld_neg;
    // drivers float once the last beat of the pending burst has gone out
    assign q_oe_o = phase ? lnk_r.vld_pos : neg_r.vld_neg;

endmodule : qsp_sram_port

`default_nettype wire

/* dv/qsp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module qsp_ctrl_model
(
    output logic k_clk_o, // positive input clock, free running
    output logic k_n_clk_o, // negative input clock
    output logic read_port_select_n_o, // read select, active low
    output logic write_port_select_n_o, // write select, active low
    output qsp_pkg::qsp_mask_t byte_write_select_n_o, // byte selects, active low
    output qsp_pkg::qsp_addr_t addr_o, // shared address
    output qsp_pkg::qsp_word_t data_o, // write data
    input wire logic [`QSP_DW-1:0] q_i, // read data
    input wire logic valid_i // read data valid
);
    import qsp_pkg::*;
    qsp_word_t rdq[$];

    initial
    begin
        k_clk_o = 1'b0;
        k_n_clk_o = 1'b1;
        read_port_select_n_o = 1'b1;
        write_port_select_n_o = 1'b1;
        byte_write_select_n_o = 4'hF;
        addr_o = 18'h0_0000;
        data_o = 36'h0_0000_0000;
        #7;
        forever
        begin
            #80;
            k_clk_o = ~k_clk_o;
            k_n_clk_o = ~k_clk_o;
        end
    end

    // a beat is taken at the edge that ends it, before that edge's updates land
    always @(posedge k_clk_o or posedge k_n_clk_o)
    begin
        if (valid_i === 1'b1)
        begin
            rdq.push_back(q_i);
        end
    end

    // dbl keeps the selects low over the next k rise, which the device must refuse
    task automatic issue(input logic rd, input logic wr, input logic dbl, input qsp_addr_t a,
        input qsp_burst_t d, input qsp_bmask_t m);
        @(posedge k_n_clk_o);
        #2;
        read_port_select_n_o = ~rd;
        write_port_select_n_o = ~wr;
        addr_o = a;
        data_o = d[0];
        byte_write_select_n_o = m[0];
        @(posedge k_clk_o);
        #2;
        read_port_select_n_o = ~(rd & dbl);
        write_port_select_n_o = ~(wr & dbl);
        addr_o = ~a;
        data_o = d[1];
        byte_write_select_n_o = m[1];
        @(posedge k_n_clk_o);
        #2;
        data_o = d[2];
        byte_write_select_n_o = m[2];
        @(posedge k_clk_o);
        #2;
        read_port_select_n_o = 1'b1;
        write_port_select_n_o = 1'b1;
        data_o = d[3];
        byte_write_select_n_o = m[3];
    endtask : issue

    // an idle bus never holds its last value, so a stray sample shows up
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge k_n_clk_o);
            #2;
            data_o = ~data_o;
            addr_o = ~addr_o;
            byte_write_select_n_o = ~byte_write_select_n_o;
        end
    endtask : idle
endmodule : qsp_ctrl_model

`default_nettype wire

/* dv/qsp_sram_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module qsp_sram_port_assertions
(
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // reset, active low
    input wire logic k_clk_i, // positive input clock
    input wire logic k_n_clk_i, // negative input clock
    input wire logic read_port_select_n_i, // read select
    input wire logic write_port_select_n_i, // write select
    input wire qsp_pkg::qsp_mask_t byte_write_select_n_i, // byte selects
    input wire qsp_pkg::qsp_addr_t addr_i, // address
    input wire qsp_pkg::qsp_word_t data_i, // write data
    input wire logic [`QSP_DW-1:0] q_o, // read data
    input wire logic q_oe_o, // read drive enable
    input wire logic output_valid_flag_o, // read data valid
    input wire logic echo_timing_out_o, // echo clock
    input wire logic echo_timing_out_n_o // inverted echo clock
);
    logic [2:0] k_cnt_r;
    logic rd_took_r;
    logic [3:0] quiet_r;
    logic [3:0] vrun_r;
    logic live;
    logic rd_take;

    // link flops leave reset a few k edges late, so checks wait for a settled count
    assign live = (k_cnt_r == 3'h7);
    assign rd_take = live && !read_port_select_n_i && !rd_took_r;

    always_ff @(posedge k_clk_i)
    begin
        k_cnt_r <= !rst_n_i ? 3'h0 : (live ? k_cnt_r : k_cnt_r + 3'h1);
        rd_took_r <= rst_n_i && rd_take;
        quiet_r <= (!rst_n_i || rd_take) ? 4'h0 : (&quiet_r ? quiet_r : quiet_r + 4'h1);
    end

    always_ff @(posedge k_n_clk_i)
    begin
        vrun_r <= (!rst_n_i || !output_valid_flag_o) ? 4'h0 : vrun_r + 4'h1;
    end

    a_oe_is_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q_oe_o == output_valid_flag_o) else $error("drive enable differs from valid");
    a_echo_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        echo_timing_out_n_o == !echo_timing_out_o) else $error("echo pair not inverse");
    a_echo_low_k: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
        live |-> !echo_timing_out_o) else $error("echo not low before k rise");
    a_echo_high_kn: assert property (@(posedge k_n_clk_i) disable iff (!rst_n_i)
        live |-> echo_timing_out_o) else $error("echo not high before negative rise");
    a_valid_on_echo: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(output_valid_flag_o) |-> $rose(echo_timing_out_o))
        else $error("valid moved off the echo rise");
    a_q_on_echo: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        output_valid_flag_o && $changed(q_o) |-> $changed(echo_timing_out_o))
        else $error("read data moved off an echo edge");
    a_read_answer: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
        rd_take |-> ##[1:10] output_valid_flag_o) else $error("read got no data");
    a_no_stray: assert property (@(posedge k_clk_i) disable iff (!rst_n_i)
        quiet_r == 4'hF |-> !output_valid_flag_o) else $error("valid without a read");
    a_burst_len: assert property (@(posedge k_n_clk_i) disable iff (!rst_n_i)
        $fell(output_valid_flag_o) |-> vrun_r != 4'h0 && vrun_r[0] == 1'b0)
        else $error("valid run not whole bursts");
endmodule : qsp_sram_port_assertions

bind qsp_sram_port qsp_sram_port_assertions i_chk (.clk_i, .rst_n_i, .k_clk_i, .k_n_clk_i,
    .read_port_select_n_i, .write_port_select_n_i, .byte_write_select_n_i, .addr_i, .data_i,
    .q_o, .q_oe_o, .output_valid_flag_o, .echo_timing_out_o, .echo_timing_out_n_o);

`default_nettype wire

/* dv/tb_qsp_sram_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module tb_qsp_sram_port;
    import qsp_pkg::*;
    typedef struct {qsp_addr_t a; qsp_bmask_t m;} qsp_row_t;

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic k_clk_i, k_n_clk_i, read_port_select_n_i, write_port_select_n_i;
    qsp_mask_t byte_write_select_n_i;
    qsp_addr_t addr_i;
    qsp_word_t data_i;
    logic [`QSP_DW-1:0] q_o;
    logic q_oe_o, output_valid_flag_o, echo_timing_out_o, echo_timing_out_n_o;
    int num_errors = 0;
    int cmp_count = 0;
    qsp_word_t mem[qsp_maddr_t];
    qsp_word_t junk = 36'h9_6969_6969;
    // full-lane, no-lane, alternate-lane and three-lane-per-beat masks at edge and patterned addresses
    qsp_row_t rows[4] = '{'{18'h0_0000, 16'h0000}, '{18'h3_FFFF, 16'hFFFF},
        '{18'h1_2345, 16'h5A5A}, '{18'h2_AAAA, 16'h8421}};

    qsp_sram_port i_dut (.clk_i, .rst_n_i, .k_clk_i, .k_n_clk_i, .read_port_select_n_i,
        .write_port_select_n_i, .byte_write_select_n_i, .addr_i, .data_i, .q_o, .q_oe_o,
        .output_valid_flag_o, .echo_timing_out_o, .echo_timing_out_n_o);

    qsp_ctrl_model i_ctrl (.k_clk_o(k_clk_i), .k_n_clk_o(k_n_clk_i),
        .read_port_select_n_o(read_port_select_n_i),
        .write_port_select_n_o(write_port_select_n_i),
        .byte_write_select_n_o(byte_write_select_n_i), .addr_o(addr_i), .data_o(data_i),
        .q_i(q_o), .valid_i(output_valid_flag_o));

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict;
        $display("comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic fill(input qsp_addr_t a, input qsp_bmask_t m, input logic [7:0] s,
        input logic dbl);
        qsp_burst_t d;
        for (int b = 0; b < 4; b++)
        begin
            d[b] = {s, 2'(b), 8'h5A ^ s, a};
            for (int n = 0; n < 4; n++)
            begin
                if (!m[b][n])
                begin
                    mem[{a, 2'(b)}][9*n +: 9] = d[b][9*n +: 9];
                end
            end
        end
        i_ctrl.issue(1'b0, 1'b1, dbl, a, d, m);
    endtask : fill

    task automatic wait_beats(input int n);
        int t;
        t = 0;
        while (i_ctrl.rdq.size() < n && t < 120)
        begin
            @(posedge clk_i);
            t++;
        end
    endtask : wait_beats

    task automatic chk_burst(input qsp_addr_t a, input int base);
        for (int b = 0; b < 4; b++)
        begin
            check("read beat", mem[{a, 2'(b)}], i_ctrl.rdq[base+b]);
        end
    endtask : chk_burst

    initial
    begin
        #100_000;
        num_errors++;
        give_verdict();
    end

    initial
    begin
        // the link needs three k rises inside reset, more than ten system cycles
        repeat (24) @(posedge clk_i);
        check("drive enable in reset", 1'b0, q_oe_o);
        #2;
        rst_n_i = 1'b1;
        repeat (8) @(posedge k_clk_i);
        foreach (rows[i])
        begin
            fill(rows[i].a, 16'h0000, 8'(i), 1'b0);
            fill(rows[i].a, rows[i].m, 8'(i) ^ 8'hFF, 1'b0);
            i_ctrl.idle(4);
            i_ctrl.rdq.delete();
            i_ctrl.issue(1'b1, 1'b0, 1'b0, rows[i].a, {4{junk}}, 16'hFFFF);
            wait_beats(4);
            check("beat count", 36'(4), 36'(i_ctrl.rdq.size()));
            chk_burst(rows[i].a, 0);
            i_ctrl.idle(4);
        end
        i_ctrl.rdq.delete();
        i_ctrl.issue(1'b1, 1'b0, 1'b0, rows[0].a, {4{junk}}, 16'hFFFF);
        i_ctrl.issue(1'b1, 1'b0, 1'b0, rows[2].a, {4{junk}}, 16'hFFFF);
        wait_beats(8);
        chk_burst(rows[0].a, 0);
        chk_burst(rows[2].a, 4);
        i_ctrl.idle(4);
        i_ctrl.rdq.delete();
        i_ctrl.issue(1'b1, 1'b0, 1'b1, rows[3].a, {4{junk}}, 16'hFFFF);
        wait_beats(8);
        check("refused read beats", 36'(4), 36'(i_ctrl.rdq.size()));
        chk_burst(rows[3].a, 0);
        // a write select held over the next k rise must not restart the burst
        i_ctrl.idle(4);
        fill(rows[3].a, 16'h0000, 8'h77, 1'b1);
        i_ctrl.idle(4);
        i_ctrl.rdq.delete();
        i_ctrl.issue(1'b1, 1'b0, 1'b0, rows[3].a, {4{junk}}, 16'hFFFF);
        wait_beats(4);
        chk_burst(rows[3].a, 0);
        i_ctrl.idle(16);
        check("drive enable idle", 1'b0, q_oe_o);
        @(posedge clk_i);
        #2;
        rst_n_i = 1'b0;
        repeat (24) @(posedge clk_i);
        check("valid in reset", 1'b0, output_valid_flag_o);
        check("echo in reset", 1'b0, echo_timing_out_o);
        #2;
        rst_n_i = 1'b1;
        repeat (8) @(posedge k_clk_i);
        give_verdict();
    end
endmodule : tb_qsp_sram_port

`default_nettype wire
